// File: hw/sfw_reg_bank.sv
/*
  Capability word, station address, station alias and the two write
  protection schemes of a fieldbus slave controller.
  Local writes reach only the station alias; every other local write is
  dropped. Read data is registered and holds until the next read strobe
  of the same port. An unlock lives for one frame only, and a refused
  network write leaves every register as it was.
  Assumes byte accesses from the network side port and the local process
  port, frame start/end pulses from the frame engine, and that the rest
  of the device gates its own network writes with net_wr_allow_out.
*/
`timescale 1ns/100ps
module sfw_reg_bank #(
  parameter logic CAP_BYTE_MAP     = 1'b1,
  parameter logic CAP_TIME_SYNC    = 1'b1,
  parameter logic CAP_TIME_64      = 1'b1,
  parameter logic CAP_MII_LINK_DET = 1'b0,
  parameter logic CAP_FCS_SPLIT    = 1'b1,
  parameter logic CAP_SYNC_ENH     = 1'b1,
  parameter logic CAP_NO_LRW       = 1'b0,
  parameter logic CAP_NO_RW_CMD    = 1'b0,
  parameter logic CAP_FIXED_CFG    = 1'b0
) (
  input  wire logic        clk_sys_in,       // System clock, 125 MHz
  input  wire logic        reset_in,         // Sync power-on reset
  input  wire logic        frame_start_in,   // Frame start pulse
  input  wire logic        frame_end_in,     // Frame end pulse
  input  wire logic [15:0] net_addr_in,      // Network byte address
  input  wire logic [7:0]  net_wdata_in,     // Network write data
  input  wire logic        net_wr_in,        // Network write strobe
  input  wire logic        net_rd_in,        // Network read strobe
  output logic      [7:0]  net_rdata_out,    // Network read data
  output logic             net_wr_allow_out, // Write at address allowed
  input  wire logic [15:0] loc_addr_in,      // Local byte address
  input  wire logic [7:0]  loc_wdata_in,     // Local write data
  input  wire logic        loc_wr_in,        // Local write strobe
  input  wire logic        loc_rd_in,        // Local read strobe
  output logic      [7:0]  loc_rdata_out,    // Local read data
  input  wire logic        mem_load_in,      // Config memory load pulse
  input  wire logic [15:0] mem_alias_in,     // Alias from config memory
  input  wire logic        alias_en_in,      // Alias matching enable
  input  wire logic [15:0] cmd_addr_in,      // Configured command address
  output logic             cmd_match_out,    // Configured address hit
  output logic      [15:0] node_address_out  // Current station address
);

  // ********************************************************************
  // Capability word
  // ********************************************************************
  logic [15:0] cap_word;
  assign cap_word = {4'h0,
                     CAP_FIXED_CFG,
                     CAP_NO_RW_CMD,
                     CAP_NO_LRW,
                     CAP_SYNC_ENH,
                     CAP_FCS_SPLIT,
                     CAP_MII_LINK_DET, 2'b00,
                     CAP_TIME_64, CAP_TIME_SYNC, 1'b0,
                     CAP_BYTE_MAP};

  // ********************************************************************
  // Address decode
  // ********************************************************************
  // Network and local offset hits
  logic net_at_addr_lo;
  logic net_at_addr_hi;
  logic net_at_range_lock;
  logic net_at_dev_lock;
  logic loc_at_alias_lo;
  logic loc_at_alias_hi;

  assign net_at_addr_lo    = (net_addr_in == sfw_pkg::OFS_ADDR_LO);
  assign net_at_addr_hi    = (net_addr_in == sfw_pkg::OFS_ADDR_HI);
  assign net_at_range_lock = (net_addr_in == sfw_pkg::OFS_RANGE_LOCK);
  assign net_at_dev_lock   = (net_addr_in == sfw_pkg::OFS_DEV_LOCK);
  assign loc_at_alias_lo   = (loc_addr_in == sfw_pkg::OFS_ALIAS_LO);
  assign loc_at_alias_hi   = (loc_addr_in == sfw_pkg::OFS_ALIAS_HI);

  // ********************************************************************
  // Write protection decode
  // ********************************************************************
  function automatic logic in_prot_range(input logic [15:0] a);
    in_prot_range = (a <= sfw_pkg::RANGE_A_LAST) ||
                    (a >= sfw_pkg::RANGE_B_FIRST &&
                     a <= sfw_pkg::RANGE_B_LAST);
  endfunction

  logic range_lock;
  logic range_unlocked;
  logic range_unlk_bit;
  logic dev_lock;
  logic dev_unlocked;
  logic dev_unlk_bit;
  logic is_dev_unlk;
  logic is_range_unlk;
  logic range_block;
  logic dev_block;
  logic net_wr_ok;

  assign is_dev_unlk   = (net_addr_in == sfw_pkg::OFS_DEV_UNLK);
  assign is_range_unlk = (net_addr_in == sfw_pkg::OFS_RANGE_UNLK);
  // Range unlock location is itself exempt so the scheme can be lifted
  assign range_block   = range_lock && !range_unlocked &&
                         in_prot_range(net_addr_in) &&
                         !is_dev_unlk && !is_range_unlk;
  assign dev_block     = dev_lock && !dev_unlocked &&
                         !is_dev_unlk;
  assign net_wr_allow_out = !(range_block || dev_block);
  assign net_wr_ok     = net_wr_in && net_wr_allow_out;

  // ********************************************************************
  // Write strobes
  // ********************************************************************
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic wr_alias_lo;
  logic wr_alias_hi;
  logic wr_range_unlk;
  logic wr_range_lock;
  logic wr_dev_unlk;
  logic wr_dev_lock;
  logic alias_load;
  logic alias_loaded_q;

  assign wr_addr_lo    = net_wr_ok && net_at_addr_lo;
  assign wr_addr_hi    = net_wr_ok && net_at_addr_hi;
  assign wr_alias_lo   = loc_wr_in && loc_at_alias_lo;
  assign wr_alias_hi   = loc_wr_in && loc_at_alias_hi;
  assign wr_range_unlk = net_wr_ok && is_range_unlk;
  assign wr_range_lock = net_wr_ok && net_at_range_lock;
  assign wr_dev_unlk   = net_wr_ok && is_dev_unlk;
  assign wr_dev_lock   = net_wr_ok && net_at_dev_lock;

  // ********************************************************************
  // Station alias load
  // ********************************************************************
  // Only the first memory load after power-on may set the alias
  assign alias_load    = mem_load_in && !alias_loaded_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      alias_loaded_q <= 1'b0;
    end else if (mem_load_in) begin
      alias_loaded_q <= 1'b1;
    end
  end

  // ********************************************************************
  // Register storage
  // ********************************************************************
  logic [15:0] node_address;
  logic [15:0] node_alias;

  sfw_word_reg #(
    .RESET_VAL    (sfw_pkg::RST_NODE_ADDR)
  ) u_node_address (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .wr_lo_in     (wr_addr_lo),
    .wr_hi_in     (wr_addr_hi),
    .wdata_in     (net_wdata_in),
    .load_in      (1'b0),
    .load_data_in (16'h0000),
    .value_out    (node_address)
  );

  sfw_word_reg #(
    .RESET_VAL    (sfw_pkg::RST_NODE_ALIAS)
  ) u_node_alias (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .wr_lo_in     (wr_alias_lo),
    .wr_hi_in     (wr_alias_hi),
    .wdata_in     (loc_wdata_in),
    .load_in      (alias_load),
    .load_data_in (mem_alias_in),
    .value_out    (node_alias)
  );

  sfw_lock_unit u_range (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .frame_start_in (frame_start_in),
    .frame_end_in   (frame_end_in),
    .wr_lock_in     (wr_range_lock),
    .lock_bit_in    (net_wdata_in[sfw_pkg::LOCK_BIT]),
    .wr_unlock_in   (wr_range_unlk),
    .unlk_bit_in    (net_wdata_in[sfw_pkg::LOCK_BIT]),
    .lock_out       (range_lock),
    .unlocked_out   (range_unlocked),
    .unlk_bit_out   (range_unlk_bit)
  );

  sfw_lock_unit u_device (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .frame_start_in (frame_start_in),
    .frame_end_in   (frame_end_in),
    .wr_lock_in     (wr_dev_lock),
    .lock_bit_in    (net_wdata_in[sfw_pkg::LOCK_BIT]),
    .wr_unlock_in   (wr_dev_unlk),
    .unlk_bit_in    (net_wdata_in[sfw_pkg::LOCK_BIT]),
    .lock_out       (dev_lock),
    .unlocked_out   (dev_unlocked),
    .unlk_bit_out   (dev_unlk_bit)
  );

  // ********************************************************************
  // Address matching
  // ********************************************************************
  logic addr_hit;
  logic alias_hit;

  assign addr_hit         = (cmd_addr_in == node_address);
  assign alias_hit        = alias_en_in &&
                            (cmd_addr_in == node_alias);
  assign cmd_match_out    = addr_hit || alias_hit;
  assign node_address_out = node_address;

  // ********************************************************************
  // Read path
  // ********************************************************************
  function automatic logic [7:0] rd_mux(
    input logic [15:0] a,
    input logic [15:0] cap,
    input logic [15:0] adr,
    input logic [15:0] als,
    input logic [3:0]  prot
  );
    unique case (a)
      sfw_pkg::OFS_CAP_LO:     rd_mux = cap[7:0];
      sfw_pkg::OFS_CAP_HI:     rd_mux = cap[15:8];
      sfw_pkg::OFS_ADDR_LO:    rd_mux = adr[7:0];
      sfw_pkg::OFS_ADDR_HI:    rd_mux = adr[15:8];
      sfw_pkg::OFS_ALIAS_LO:   rd_mux = als[7:0];
      sfw_pkg::OFS_ALIAS_HI:   rd_mux = als[15:8];
      sfw_pkg::OFS_RANGE_UNLK: rd_mux = {7'h00, prot[0]};
      sfw_pkg::OFS_RANGE_LOCK: rd_mux = {7'h00, prot[1]};
      sfw_pkg::OFS_DEV_UNLK:   rd_mux = {7'h00, prot[2]};
      sfw_pkg::OFS_DEV_LOCK:   rd_mux = {7'h00, prot[3]};
      default:                 rd_mux = sfw_pkg::RD_ZERO;
    endcase
  endfunction

  logic [3:0] prot_bits;
  logic [7:0] net_rdata_q;
  logic [7:0] loc_rdata_q;
  logic [7:0] net_rdata_d;
  logic [7:0] loc_rdata_d;
  logic [7:0] net_rd_val;
  logic [7:0] loc_rd_val;

  assign prot_bits   = {dev_lock, dev_unlk_bit, range_lock, range_unlk_bit};
  assign net_rd_val  = rd_mux(net_addr_in, cap_word, node_address,
                              node_alias, prot_bits);
  assign loc_rd_val  = rd_mux(loc_addr_in, cap_word, node_address,
                              node_alias, prot_bits);
  // Read data holds between strobes
  assign net_rdata_d = net_rd_in ? net_rd_val : net_rdata_q;
  assign loc_rdata_d = loc_rd_in ? loc_rd_val : loc_rdata_q;
  assign net_rdata_out = net_rdata_q;
  assign loc_rdata_out = loc_rdata_q;

  // ********************************************************************
  // Read data registers
  // ********************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      net_rdata_q <= sfw_pkg::RD_ZERO;
    end else begin
      net_rdata_q <= net_rdata_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      loc_rdata_q <= sfw_pkg::RD_ZERO;
    end else begin
      loc_rdata_q <= loc_rdata_d;
    end
  end

endmodule

// File: include/sfw_pkg.sv
/*
  Package for the capability, station address and write protection bank.
  Holds byte offsets, protected range bounds and reset values.
  Assumes byte-wide accesses from both access ports.
*/
package sfw_pkg;

  // ********************************************************************
  // Byte offsets
  // ********************************************************************
  localparam logic [15:0] OFS_CAP_LO      = 16'h0008;
  localparam logic [15:0] OFS_CAP_HI      = 16'h0009;
  localparam logic [15:0] OFS_ADDR_LO     = 16'h0010;
  localparam logic [15:0] OFS_ADDR_HI     = 16'h0011;
  localparam logic [15:0] OFS_ALIAS_LO    = 16'h0012;
  localparam logic [15:0] OFS_ALIAS_HI    = 16'h0013;
  localparam logic [15:0] OFS_RANGE_UNLK  = 16'h0020;
  localparam logic [15:0] OFS_RANGE_LOCK  = 16'h0021;
  localparam logic [15:0] OFS_DEV_UNLK    = 16'h0030;
  localparam logic [15:0] OFS_DEV_LOCK    = 16'h0031;

  // ********************************************************************
  // Protected register ranges
  // ********************************************************************
  localparam logic [15:0] RANGE_A_LAST    = 16'h0137;
  localparam logic [15:0] RANGE_B_FIRST   = 16'h013A;
  localparam logic [15:0] RANGE_B_LAST    = 16'h0F0F;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int          LOCK_BIT        = 0;
  localparam logic [15:0] RST_NODE_ADDR   = 16'h0000;
  localparam logic [15:0] RST_NODE_ALIAS  = 16'h0000;
  localparam logic [7:0]  RD_ZERO         = 8'h00;

endpackage

// File: hw/sfw_word_reg.sv
/*
  Sixteen bit register with byte writes and a whole-word load.
  Assumes strobes are one-cycle pulses on clk_sys_in.
*/
`timescale 1ns/100ps
module sfw_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic        clk_sys_in,   // System clock
  input  wire logic        reset_in,     // Sync reset, active high
  input  wire logic        wr_lo_in,     // Write low byte
  input  wire logic        wr_hi_in,     // Write high byte
  input  wire logic [7:0]  wdata_in,     // Byte write data
  input  wire logic        load_in,      // Whole-word load
  input  wire logic [15:0] load_data_in, // Load data
  output logic      [15:0] value_out     // Register contents
);

  logic [15:0] word_q;
  logic [15:0] word_d;
  logic [15:0] base;

  // Byte writes override a load in the same cycle
  assign base     = load_in ? load_data_in : word_q;
  assign word_d   = {wr_hi_in ? wdata_in : base[15:8],
                     wr_lo_in ? wdata_in : base[7:0]};
  assign value_out = word_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      word_q <= RESET_VAL;
    end else begin
      word_q <= word_d;
    end
  end

endmodule

// File: hw/sfw_lock_unit.sv
/*
  One protection scheme: lock enable bit and per-frame unlock flag.
  Assumes write strobes were already checked against protection.
*/
`timescale 1ns/100ps
module sfw_lock_unit (
  input  wire logic clk_sys_in,     // System clock
  input  wire logic reset_in,       // Sync reset, active high
  input  wire logic frame_start_in, // Frame start pulse
  input  wire logic frame_end_in,   // Frame end pulse
  input  wire logic wr_lock_in,     // Accepted write to lock register
  input  wire logic lock_bit_in,    // Bit 0 of lock write data
  input  wire logic wr_unlock_in,   // Accepted write to unlock register
  input  wire logic unlk_bit_in,    // Bit 0 of unlock write data
  output logic      lock_out,       // Protection enabled
  output logic      unlocked_out,   // Unlocked for this frame
  output logic      unlk_bit_out    // Stored unlock bit for readback
);

  logic lock_q;
  logic unlocked_q;
  logic unlk_bit_q;
  logic unlocked_d;

  // Unlock write wins over the frame boundary clear
  assign unlocked_d = wr_unlock_in ? 1'b1 :
                      (frame_start_in || frame_end_in) ? 1'b0 :
                      unlocked_q;

  assign lock_out     = lock_q;
  assign unlocked_out = unlocked_q;
  assign unlk_bit_out = unlk_bit_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      lock_q     <= 1'b0;
      unlocked_q <= 1'b0;
      unlk_bit_q <= 1'b0;
    end else begin
      lock_q     <= wr_lock_in ? lock_bit_in : lock_q;
      unlocked_q <= unlocked_d;
      unlk_bit_q <= wr_unlock_in ? unlk_bit_in : unlk_bit_q;
    end
  end

endmodule

// File: dv/sfw_monitor.sv
/* Checker for the protection bank, bound into sfw_reg_bank.
   Assumes the default capability parameters of the bank. */
`timescale 1ns/100ps
module sfw_monitor (
  input wire logic        clk_sys_in,       // System clock
  input wire logic        reset_in,         // Sync reset
  input wire logic        frame_start_in,   // Frame begins
  input wire logic        frame_end_in,     // Frame ends
  input wire logic [15:0] net_addr_in,      // Network address
  input wire logic [7:0]  net_wdata_in,     // Network write data
  input wire logic        net_wr_in,        // Network write
  input wire logic        net_rd_in,        // Network read
  input wire logic [7:0]  net_rdata_out,    // Network read data
  input wire logic        net_wr_allow_out, // Write allowed
  input wire logic [15:0] node_address_out  // Station address
);
  // ********************
  // Lock state from accepted writes
  // ********************
  wire acc   = net_wr_in && net_wr_allow_out;
  wire fr    = frame_start_in || frame_end_in;
  wire w_ad  = acc && (net_addr_in == sfw_pkg::OFS_ADDR_LO ||
                       net_addr_in == sfw_pkg::OFS_ADDR_HI);
  wire hit0  = net_addr_in == sfw_pkg::OFS_DEV_UNLK;
  wire in_a  = net_addr_in <= sfw_pkg::RANGE_A_LAST;
  wire in_b  = net_addr_in >= sfw_pkg::RANGE_B_FIRST &&
               net_addr_in <= sfw_pkg::RANGE_B_LAST;
  wire in_r  = (in_a || in_b) && !hit0 &&
               net_addr_in != sfw_pkg::OFS_RANGE_UNLK;
  wire rd_cl = net_rd_in && net_addr_in == sfw_pkg::OFS_CAP_LO;
  wire rd_ch = net_rd_in && net_addr_in == sfw_pkg::OFS_CAP_HI;
  wire rd_dl = net_rd_in && net_addr_in == sfw_pkg::OFS_DEV_LOCK;
  logic rlk_q, rul_q, dlk_q, dul_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      {rlk_q, rul_q, dlk_q, dul_q} <= 4'h0;
    end else begin
      if (acc && net_addr_in == sfw_pkg::OFS_RANGE_LOCK)
        rlk_q <= net_wdata_in[0];
      if (acc && net_addr_in == sfw_pkg::OFS_DEV_LOCK)
        dlk_q <= net_wdata_in[0];
      rul_q <= (acc && net_addr_in == sfw_pkg::OFS_RANGE_UNLK) ||
               (rul_q && !fr);
      dul_q <= (acc && hit0) || (dul_q && !fr);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  cap_low_a: assert property (
    rd_cl |=> net_rdata_out == 8'h8D) else $error("capability low");
  cap_high_a: assert property (
    rd_ch |=> net_rdata_out == 8'h01) else $error("capability high");
  addr_write_a: assert property (
    acc && net_addr_in == sfw_pkg::OFS_ADDR_LO |=>
    node_address_out[7:0] == $past(net_wdata_in)) else $error("addr lo");
  addr_hold_a: assert property (
    !w_ad |=> $stable(node_address_out)) else $error("addr changed");
  range_block_a: assert property (
    rlk_q && !rul_q && in_r |-> !net_wr_allow_out) else $error("range");
  dev_block_a: assert property (
    dlk_q && !dul_q && !hit0 |-> !net_wr_allow_out) else $error("device");
  open_write_a: assert property (
    (!rlk_q || rul_q) && (!dlk_q || dul_q) || hit0 |-> net_wr_allow_out)
    else $error("write wrongly blocked");
  lock_read_a: assert property (
    rd_dl |=> net_rdata_out == {7'h00, $past(dlk_q)}) else $error("lock rd");
  unlk_c: cover property (dlk_q && dul_q && net_wr_in);
  rblk_c: cover property (rlk_q && !rul_q && in_r && net_wr_in);
  fend_c: cover property (dul_q && frame_end_in);
endmodule
bind sfw_reg_bank sfw_monitor mon (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .frame_start_in(frame_start_in), .frame_end_in(frame_end_in),
  .net_addr_in(net_addr_in), .net_wdata_in(net_wdata_in),
  .net_wr_in(net_wr_in), .net_rd_in(net_rd_in),
  .net_rdata_out(net_rdata_out), .net_wr_allow_out(net_wr_allow_out),
  .node_address_out(node_address_out));

// File: dv/sfw_net_master.sv
/* Network master model: frame pulses and byte accesses.
   Assumes the bank samples on the rising edge of clk_sys_in. */
`timescale 1ns/100ps
module sfw_net_master (
  input  wire logic        clk_sys_in,      // System clock
  input  wire logic [7:0]  net_rdata_in,    // Read data
  output logic             frame_start_out, // Frame begins
  output logic             frame_end_out,   // Frame ends
  output logic      [15:0] net_addr_out,    // Byte address
  output logic      [7:0]  net_wdata_out,   // Write data
  output logic             net_wr_out,      // Write strobe
  output logic             net_rd_out       // Read strobe
);
  // ********************
  // Frame and byte tasks
  // ********************
  initial begin
    frame_start_out = 1'b0;
    frame_end_out   = 1'b0;
    net_wr_out      = 1'b0;
    net_rd_out      = 1'b0;
    net_addr_out  = 16'h0000;
    net_wdata_out = 8'h00;
  end
  task automatic frame(input logic start);
    @(negedge clk_sys_in);
    frame_start_out = start;
    frame_end_out   = !start;
    @(negedge clk_sys_in);
    frame_start_out = 1'b0;
    frame_end_out   = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    net_addr_out  = a;
    net_wdata_out = d;
    net_wr_out    = 1'b1;
    @(negedge clk_sys_in);
    net_wr_out    = 1'b0;
    net_wdata_out = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    net_addr_out = a;
    net_rd_out   = 1'b1;
    @(negedge clk_sys_in);
    net_rd_out   = 1'b0;
    d            = net_rdata_in;
  endtask
  // Value is irrelevant; bit 0 low on purpose
  task automatic unlock(input logic [15:0] a);
    wr(a, 8'hA6);
  endtask
  task automatic lock(input logic [15:0] a, input logic b);
    wr(a, {7'h00, b});
  endtask
  task automatic aim(input logic [15:0] a);
    @(negedge clk_sys_in);
    net_addr_out = a;
  endtask
endmodule

// File: dv/testbench.sv
/* Self-checking bench for sfw_reg_bank.
   Assumes default capability parameters and the network master model. */
`timescale 1ns/100ps
module testbench;
  logic        clk_sys_in, reset_in, f_st, f_en, n_wr, n_rd, allow;
  logic        loc_wr, loc_rd, mem_load, alias_en, match;
  logic [15:0] n_addr, loc_addr, mem_alias, cmd_addr, node_addr;
  logic [7:0]  n_wdata, n_rdata, loc_wdata, loc_rdata, rd;
  int          fails, tests_run, cyc;
  sfw_reg_bank dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .frame_start_in(f_st), .frame_end_in(f_en), .net_addr_in(n_addr),
    .net_wdata_in(n_wdata), .net_wr_in(n_wr), .net_rd_in(n_rd),
    .net_rdata_out(n_rdata), .net_wr_allow_out(allow),
    .loc_addr_in(loc_addr), .loc_wdata_in(loc_wdata), .loc_wr_in(loc_wr),
    .loc_rd_in(loc_rd), .loc_rdata_out(loc_rdata), .mem_load_in(mem_load),
    .mem_alias_in(mem_alias), .alias_en_in(alias_en),
    .cmd_addr_in(cmd_addr), .cmd_match_out(match),
    .node_address_out(node_addr));
  sfw_net_master master (.clk_sys_in(clk_sys_in), .net_rdata_in(n_rdata),
    .frame_start_out(f_st), .frame_end_out(f_en), .net_addr_out(n_addr),
    .net_wdata_out(n_wdata), .net_wr_out(n_wr), .net_rd_out(n_rd));
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // ********************
  // Access and compare tasks
  // ********************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic nchk(input logic [15:0] a, input logic [7:0] e);
    master.rd(a, rd);
    chk_byte(rd, e);
  endtask
  task automatic lchk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys_in);
    loc_addr = a;
    loc_rd   = 1'b1;
    @(negedge clk_sys_in);
    loc_rd   = 1'b0;
    chk_byte(loc_rdata, e);
  endtask
  task automatic lwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    loc_addr  = a;
    loc_wdata = d;
    loc_wr    = 1'b1;
    @(negedge clk_sys_in);
    loc_wr    = 1'b0;
  endtask
  task automatic mload(input logic [15:0] v);
    @(negedge clk_sys_in);
    mem_alias = v;
    mem_load  = 1'b1;
    @(negedge clk_sys_in);
    mem_load  = 1'b0;
  endtask
  task automatic ok(input logic [15:0] a, input logic e);
    master.aim(a);
    #1;
    chk_bit(allow, e);
  endtask
  task automatic end_sim;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    loc_wr    = 1'b0;
    loc_rd    = 1'b0;
    mem_load  = 1'b0;
    alias_en  = 1'b0;
    loc_addr  = 16'h0000;
    mem_alias = 16'h0000;
    cmd_addr  = 16'h0000;
    loc_wdata = 8'h00;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_in = 1'b0;
    nchk(16'h0008, 8'h8D);
    nchk(16'h0009, 8'h01);
    master.wr(16'h0008, 8'h72);
    lwr(16'h0009, 8'hF0);
    lchk(16'h0008, 8'h8D);
    lchk(16'h0009, 8'h01);
    nchk(16'h0040, 8'h00);
    master.wr(16'h0010, 8'h34);
    master.wr(16'h0011, 8'h12);
    lwr(16'h0010, 8'h99);
    lchk(16'h0010, 8'h34);
    nchk(16'h0011, 8'h12);
    chk_byte(node_addr[7:0], 8'h34);
    chk_byte(node_addr[15:8], 8'h12);
    mload(16'hA55A);
    mload(16'h1111);
    nchk(16'h0012, 8'h5A);
    master.wr(16'h0013, 8'h00);
    lchk(16'h0013, 8'hA5);
    lwr(16'h0012, 8'h77);
    nchk(16'h0012, 8'h77);
    cmd_addr = 16'hA577;
    alias_en = 1'b1;
    #1 chk_bit(match, 1'b1);
    @(negedge clk_sys_in) alias_en = 1'b0;
    #1 chk_bit(match, 1'b0);
    @(negedge clk_sys_in) cmd_addr = 16'h1234;
    #1 chk_bit(match, 1'b1);
    master.frame(1'b1);
    master.lock(16'h0021, 1'b1);
    nchk(16'h0021, 8'h01);
    master.frame(1'b0);
    master.frame(1'b1);
    ok(16'h0137, 1'b0);
    ok(16'h0138, 1'b1);
    ok(16'h0F0F, 1'b0);
    ok(16'h0F10, 1'b1);
    ok(16'h0030, 1'b1);
    master.wr(16'h0010, 8'h56);
    nchk(16'h0010, 8'h34);
    master.unlock(16'h0020);
    master.wr(16'h0010, 8'h56);
    nchk(16'h0010, 8'h56);
    nchk(16'h0020, 8'h00);
    master.frame(1'b0);
    ok(16'h0010, 1'b0);
    master.unlock(16'h0020);
    master.lock(16'h0021, 1'b0);
    ok(16'h0010, 1'b1);
    master.lock(16'h0031, 1'b1);
    lwr(16'h0031, 8'h00);
    lchk(16'h0031, 8'h01);
    nchk(16'h0031, 8'h01);
    ok(16'h1000, 1'b0);
    master.unlock(16'h0030);
    ok(16'h1000, 1'b1);
    master.frame(1'b1);
    ok(16'h1000, 1'b0);
    master.unlock(16'h0030);
    master.lock(16'h0031, 1'b0);
    ok(16'h1000, 1'b1);
    master.lock(16'h0021, 1'b1);
    @(negedge clk_sys_in) reset_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    nchk(16'h0021, 8'h00);
    mload(16'h0F0F);
    nchk(16'h0013, 8'h0F);
    end_sim();
  end
endmodule
